// >>> logic/touch_cmd_pkg.sv
package touch_cmd_pkg;

   localparam logic [7:0] CMD_NULL       = 8'h00;
   localparam logic [7:0] CMD_SETUP      = 8'h01;
   localparam logic [7:0] CMD_CAL_ALL    = 8'h03;
   localparam logic [7:0] CMD_RESET      = 8'h04;
   localparam logic [7:0] CMD_STATUS     = 8'h05;
   localparam logic [7:0] CMD_FIRST_KEY  = 8'h06;
   localparam logic [7:0] CMD_ALL_KEYS   = 8'h07;
   localparam logic [7:0] CMD_ERR_FLAGS  = 8'h0B;
   localparam logic [7:0] CMD_LINE_STAT  = 8'h0C;
   localparam logic [7:0] CMD_DUMP       = 8'h0D;
   localparam logic [7:0] CMD_NV_CRC     = 8'h0E;
   localparam logic [7:0] CMD_LAST       = 8'h0F;
   localparam logic [7:0] CMD_CODE_A     = 8'h10;
   localparam logic [7:0] CMD_CODE_B     = 8'h12;
   localparam logic [1:0] GRP_KEY_DATA   = 2'h1;
   localparam logic [1:0] GRP_KEY_STAT   = 2'h2;
   localparam logic [1:0] GRP_CAL_KEY    = 2'h3;
   localparam logic [2:0] CAL_KEY_PREFIX = 3'h6;
   localparam logic [5:0] LAST_KEY       = 6'h17;

   localparam logic [7:0] ACK_READY      = 8'hFE;
   localparam logic [7:0] ACK_CRC_FAIL   = 8'h00;

   localparam logic [6:0] SETUP_BYTES    = 7'h64;
   localparam logic [7:0] CRC_INIT       = 8'h00;
   localparam logic [7:0] CRC_SKIP       = 8'h00;
   localparam logic [7:0] CRC_POLY       = 8'h07;

   localparam int STAT_COMM_ERR   = 6;
   localparam int STAT_LINE_FAULT = 5;
   localparam int STAT_SYNC_FAIL  = 3;
   localparam int STAT_CAL_FAULT  = 2;
   localparam int STAT_ANY_CAL    = 1;
   localparam int STAT_ANY_TOUCH  = 0;

   localparam int CLK_HZ         = 100_000_000;
   localparam int WINDOW_MS      = 100;
   localparam int WINDOW_CYCLES  = CLK_HZ / 1000 * WINDOW_MS;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_SLOT_WAIT,
      ST_SETUP_ACK,
      ST_SETUP_DATA,
      ST_PROGRAM,
      ST_RESET_ACK
   } mode_t;

   typedef struct packed {
      logic lineFault;
      logic syncFail;
      logic calFault;
      logic anyCal;
      logic anyTouch;
   } sense_status_t;

   typedef struct packed {
      logic       strobe;
      logic [6:0] addr;
      logic [7:0] data;
   } nv_write_t;

   typedef struct packed {
      mode_t      mode;
      logic [7:0] pendCmd;
      logic       pendValid;
      logic [7:0] lastCmd;
      logic       commErr;
      logic [7:0] resp0;
      logic [7:0] resp1;
      logic [1:0] respCount;
      logic [7:0] txByte;
      logic       txStrobe;
      logic [6:0] byteCount;
      logic [7:0] crcAcc;
      logic       crcGood;
      logic       senseHalt;
      logic       calAllStart;
      logic       deviceResetReq;
      logic       calKeyStart;
      logic [4:0] calKey;
      logic       calAck;
      nv_write_t  nvWrite;
      logic       nvProgram;
      logic       fwdStrobe;
      logic [7:0] fwdCmd;
   } cmd_state_t;

endpackage : touch_cmd_pkg

// >>> logic/crc8_step.sv
`timescale 1ns/1ps
module crc8_step
   import touch_cmd_pkg::*;
(
   input  wire logic [7:0] crcIn,
   input  wire logic [7:0] dataIn,
   output logic      [7:0] crcOut
);

   // One byte folded into the running check value, most significant bit first.
   always_comb
   begin
      logic [7:0] c;
      c = crcIn ^ dataIn;
      for (int i = 0; i < 8; i++)
      begin
         c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      crcOut = c;
   end

endmodule : crc8_step

// >>> logic/win_timer.sv
`timescale 1ns/1ps
module win_timer #(
   parameter int CYCLES = 16
)
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic start,
   input  wire logic stop,
   output logic      expired
);

   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   typedef struct packed {
      logic [W-1:0] count;
      logic         running;
      logic         expired;
   } timer_state_t;

   timer_state_t s_reg;
   timer_state_t s_next;

   // A start restarts the window even while it is running.
   always_comb
   begin
      s_next = s_reg;
      s_next.expired = 1'b0;
      if (start)
      begin
         s_next.running = 1'b1;
         s_next.count = '0;
      end
      else if (stop)
      begin
         s_next.running = 1'b0;
      end
      else if (s_reg.running)
      begin
         if (s_reg.count == LAST)
         begin
            s_next.running = 1'b0;
            s_next.expired = 1'b1;
         end
         else
         begin
            s_next.count = s_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign expired = s_reg.expired;

endmodule : win_timer

// >>> logic/touch_matrix_command_handler.sv
// Functional notes
// - Single-key cal needs two copies within window.
// - Single-key cal takes key 0..23 only.
// - Single-key cal waits for that key's slot.
// - Single-key cal acknowledges with inverted command.
// - Last-command request accepted outside setup and reset ack, clears error.
// - One null byte shifts out one response byte.
// - Setup entry needs two copies, halts sensing.
// - Setup answers ready, then done or fail.
// - Setup bytes must arrive within window each.
// - Zero check byte skips the check.
// - Setup block is written regardless of check.
// - Sensing restarts by itself after setup load.
// - Cal-all needs two copies, acknowledges on start.
// - Force reset needs two copies, acknowledges first.
// - Missing second copy times out silently.
// - Status byte carries error and activity bits.
// - Communication error stays until last-command request.
// - Status reply appends check over command, status.
// - Stuck keys are recalibrated without host help.
// - Reply check folds command first, then data.
// - Last-command reply is inverted byte, no check.
`timescale 1ns/1ps
module touch_matrix_command_handler
   import touch_cmd_pkg::*;
#(
   parameter int WINDOW = WINDOW_CYCLES
)
(
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic          rxValid,
   input  wire logic [7:0]    rxByte,
   output logic               txStrobe,
   output logic      [7:0]    txByte,
   input  wire sense_status_t senseStatus,
   input  wire logic          slotStart,
   input  wire logic [4:0]    slotKey,
   input  wire logic          stuckKey,
   input  wire logic [4:0]    stuckKeyIndex,
   input  wire logic          nvDone,
   output logic               senseHalt,
   output logic               calAllStart,
   output logic               deviceResetReq,
   output logic               calKeyStart,
   output logic      [4:0]    calKeyIndex,
   output nv_write_t          nvWrite,
   output logic               nvProgram,
   output logic               fwdStrobe,
   output logic      [7:0]    fwdCmd,
   output logic               commError
);

   cmd_state_t s_reg;
   cmd_state_t s_next;

   logic       winStart;
   logic       winStop;
   logic       winExpired;
   logic       byteStart;
   logic       byteStop;
   logic       byteExpired;
   logic [7:0] statusByte;
   logic [7:0] crcCmd;
   logic [7:0] crcStatus;
   logic [7:0] crcSetup;

   function automatic logic isKeyCmd(input logic [7:0] b, input logic [1:0] grp);
      return (b[7:6] == grp) && (b[5:0] <= LAST_KEY);
   endfunction : isKeyCmd

   function automatic logic isDouble(input logic [7:0] b);
      return (b == CMD_SETUP) || (b == CMD_CAL_ALL) || (b == CMD_RESET) || isKeyCmd(b, GRP_CAL_KEY);
   endfunction : isDouble

   function automatic logic isForwarded(input logic [7:0] b);
      return (b == CMD_FIRST_KEY) || (b == CMD_ALL_KEYS) || (b == CMD_ERR_FLAGS) || (b == CMD_LINE_STAT)
             || (b == CMD_DUMP) || (b == CMD_NV_CRC) || (b == CMD_CODE_A) || (b == CMD_CODE_B)
             || isKeyCmd(b, GRP_KEY_DATA) || isKeyCmd(b, GRP_KEY_STAT);
   endfunction : isForwarded

   always_comb
   begin
      statusByte = 8'h00;
      statusByte[STAT_COMM_ERR] = s_reg.commErr;
      statusByte[STAT_LINE_FAULT] = senseStatus.lineFault;
      statusByte[STAT_SYNC_FAIL] = senseStatus.syncFail;
      statusByte[STAT_CAL_FAULT] = senseStatus.calFault;
      statusByte[STAT_ANY_CAL] = senseStatus.anyCal;
      statusByte[STAT_ANY_TOUCH] = senseStatus.anyTouch;
   end

   // The reply check starts from the command code and then takes the status byte.
   crc8_step u_crcCmd (
      .crcIn  (CRC_INIT),
      .dataIn (CMD_STATUS),
      .crcOut (crcCmd)
   );

   crc8_step u_crcStatus (
      .crcIn  (crcCmd),
      .dataIn (statusByte),
      .crcOut (crcStatus)
   );

   crc8_step u_crcSetup (
      .crcIn  (s_reg.crcAcc),
      .dataIn (rxByte),
      .crcOut (crcSetup)
   );

   win_timer #(
      .CYCLES (WINDOW)
   ) u_winTimer (
      .clk     (clk),
      .rst_b   (rst_b),
      .start   (winStart),
      .stop    (winStop),
      .expired (winExpired)
   );

   win_timer #(
      .CYCLES (WINDOW)
   ) u_byteTimer (
      .clk     (clk),
      .rst_b   (rst_b),
      .start   (byteStart),
      .stop    (byteStop),
      .expired (byteExpired)
   );

   always_comb
   begin
      s_next = s_reg;
      winStart = 1'b0;
      winStop = 1'b0;
      byteStart = 1'b0;
      byteStop = 1'b0;
      s_next.txStrobe = 1'b0;
      s_next.calAllStart = 1'b0;
      s_next.deviceResetReq = 1'b0;
      s_next.calKeyStart = 1'b0;
      s_next.nvWrite.strobe = 1'b0;
      s_next.nvProgram = 1'b0;
      s_next.fwdStrobe = 1'b0;

      if (winExpired)
         s_next.pendValid = 1'b0;

      unique case (s_reg.mode)
         ST_RUN, ST_SLOT_WAIT:
         begin
            if (rxValid && (rxByte == CMD_NULL))
            begin
               s_next.pendValid = 1'b0;
               winStop = 1'b1;
               if (s_reg.respCount != 2'd0)
               begin
                  s_next.txByte = s_reg.resp0;
                  s_next.txStrobe = 1'b1;
                  s_next.resp0 = s_reg.resp1;
                  s_next.respCount = s_reg.respCount - 2'd1;
               end
            end
            else if (rxValid)
            begin
               s_next.lastCmd = rxByte;
               s_next.respCount = 2'd0;
               if (isDouble(rxByte))
               begin
                  if (s_reg.pendValid && (s_reg.pendCmd == rxByte) && !winExpired)
                  begin
                     s_next.pendValid = 1'b0;
                     winStop = 1'b1;
                     if (s_reg.mode == ST_RUN)
                     begin
                        if (rxByte == CMD_SETUP)
                        begin
                           s_next.mode = ST_SETUP_ACK;
                           s_next.senseHalt = 1'b1;
                           s_next.resp0 = ACK_READY;
                           s_next.respCount = 2'd1;
                           byteStart = 1'b1;
                        end
                        else if (rxByte == CMD_CAL_ALL)
                        begin
                           s_next.calAllStart = 1'b1;
                           s_next.resp0 = ~rxByte;
                           s_next.respCount = 2'd1;
                        end
                        else if (rxByte == CMD_RESET)
                        begin
                           s_next.mode = ST_RESET_ACK;
                           s_next.resp0 = ~rxByte;
                           s_next.respCount = 2'd1;
                        end
                        else
                        begin
                           s_next.mode = ST_SLOT_WAIT;
                           s_next.calKey = rxByte[4:0];
                           s_next.calAck = 1'b1;
                        end
                     end
                  end
                  else
                  begin
                     s_next.pendCmd = rxByte;
                     s_next.pendValid = 1'b1;
                     winStart = 1'b1;
                  end
               end
               else
               begin
                  s_next.pendValid = 1'b0;
                  winStop = 1'b1;
                  if (rxByte == CMD_STATUS)
                  begin
                     s_next.resp0 = statusByte;
                     s_next.resp1 = crcStatus;
                     s_next.respCount = 2'd2;
                  end
                  else if (rxByte == CMD_LAST)
                  begin
                     s_next.resp0 = ~s_reg.lastCmd;
                     s_next.respCount = 2'd1;
                     s_next.commErr = 1'b0;
                  end
                  else if (isForwarded(rxByte))
                  begin
                     s_next.fwdStrobe = 1'b1;
                     s_next.fwdCmd = rxByte;
                  end
                  else
                  begin
                     s_next.commErr = 1'b1;
                  end
               end
            end

            if (s_reg.mode == ST_RUN && !rxValid && stuckKey)
            begin
               s_next.mode = ST_SLOT_WAIT;
               s_next.calKey = stuckKeyIndex;
               s_next.calAck = 1'b0;
            end

            // The acknowledge is queued last so that it outranks a reply of the same cycle.
            if (s_reg.mode == ST_SLOT_WAIT && slotStart && slotKey == s_reg.calKey)
            begin
               s_next.mode = ST_RUN;
               s_next.calKeyStart = 1'b1;
               if (s_reg.calAck)
               begin
                  s_next.resp0 = ~{CAL_KEY_PREFIX, s_reg.calKey};
                  s_next.respCount = 2'd1;
               end
            end
         end

         ST_SETUP_ACK:
         begin
            if (byteExpired)
            begin
               s_next.mode = ST_RUN;
               s_next.senseHalt = 1'b0;
               s_next.respCount = 2'd0;
            end
            else if (rxValid)
            begin
               s_next.txByte = s_reg.resp0;
               s_next.txStrobe = 1'b1;
               s_next.respCount = 2'd0;
               s_next.mode = ST_SETUP_DATA;
               s_next.byteCount = 7'd0;
               s_next.crcAcc = CRC_INIT;
               byteStart = 1'b1;
            end
         end

         ST_SETUP_DATA:
         begin
            if (byteExpired)
            begin
               s_next.mode = ST_RUN;
               s_next.senseHalt = 1'b0;
            end
            else if (rxValid && s_reg.byteCount != SETUP_BYTES)
            begin
               byteStart = 1'b1;
               s_next.nvWrite.strobe = 1'b1;
               s_next.nvWrite.addr = s_reg.byteCount;
               s_next.nvWrite.data = rxByte;
               s_next.crcAcc = crcSetup;
               s_next.byteCount = s_reg.byteCount + 7'd1;
            end
            else if (rxValid)
            begin
               byteStop = 1'b1;
               s_next.crcGood = (rxByte == CRC_SKIP) || (rxByte == s_reg.crcAcc);
               s_next.nvProgram = 1'b1;
               s_next.mode = ST_PROGRAM;
            end
         end

         ST_PROGRAM:
         begin
            if (nvDone)
            begin
               s_next.resp0 = s_reg.crcGood ? ACK_READY : ACK_CRC_FAIL;
               s_next.respCount = 2'd1;
               s_next.senseHalt = 1'b0;
               s_next.mode = ST_RUN;
            end
         end

         ST_RESET_ACK:
         begin
            if (rxValid && rxByte == CMD_NULL && s_reg.respCount != 2'd0)
            begin
               s_next.txByte = s_reg.resp0;
               s_next.txStrobe = 1'b1;
               s_next.respCount = 2'd0;
               s_next.deviceResetReq = 1'b1;
               s_next.mode = ST_RUN;
            end
         end

         default:
         begin
            s_next.mode = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign txStrobe       = s_reg.txStrobe;
   assign txByte         = s_reg.txByte;
   assign senseHalt      = s_reg.senseHalt;
   assign calAllStart    = s_reg.calAllStart;
   assign deviceResetReq = s_reg.deviceResetReq;
   assign calKeyStart    = s_reg.calKeyStart;
   assign calKeyIndex    = s_reg.calKey;
   assign nvWrite        = s_reg.nvWrite;
   assign nvProgram      = s_reg.nvProgram;
   assign fwdStrobe      = s_reg.fwdStrobe;
   assign fwdCmd         = s_reg.fwdCmd;
   assign commError      = s_reg.commErr;

endmodule : touch_matrix_command_handler

// >>> verif/touch_cmd_sva.sv
`timescale 1ns/1ps
module touch_cmd_sva
   import touch_cmd_pkg::*;
(
   input wire logic          clk,
   input wire logic          rst_b,
   input wire logic          rxValid,
   input wire logic [7:0]    rxByte,
   input wire logic          txStrobe,
   input wire logic [7:0]    txByte,
   input wire sense_status_t senseStatus,
   input wire logic          senseHalt,
   input wire logic          calAllStart,
   input wire logic          deviceResetReq,
   input wire logic          calKeyStart,
   input wire logic [4:0]    calKeyIndex,
   input wire nv_write_t     nvWrite,
   input wire logic          commError
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence seqDouble(logic [7:0] c);
      rxValid && rxByte == c && !senseHalt ##1 rxValid && rxByte == c && !senseHalt;
   endsequence
   sequence seqStatusPull;
      rxValid && rxByte == CMD_STATUS && !senseHalt ##1 !rxValid ##1 rxValid && rxByte == CMD_NULL;
   endsequence

   AST_CAL_ALL: assert property (seqDouble(CMD_CAL_ALL) ##0 !calAllStart |=> calAllStart)
      else $error("cal all not started");
   AST_SETUP_ENTRY: assert property (seqDouble(CMD_SETUP) |=> senseHalt)
      else $error("setup not entered");
   AST_STATUS_BYTE: assert property (seqStatusPull |=> txStrobe && txByte == {1'b0, commError,
      senseStatus.lineFault, 1'b0, senseStatus.syncFail, senseStatus.calFault, senseStatus.anyCal,
      senseStatus.anyTouch}) else $error("status byte wrong");
   AST_UNKNOWN_FLAG: assert property (rxValid && rxByte == 8'h02 && !senseHalt |=> commError)
      else $error("unknown byte not flagged");
   AST_ERR_HOLD: assert property (commError && !(rxValid && rxByte == CMD_LAST) |=> commError)
      else $error("error flag dropped");
   AST_ERR_CLEAR: assert property (rxValid && rxByte == CMD_LAST && !senseHalt |=> !commError)
      else $error("error flag not cleared");
   AST_NULL_SHIFT: assert property (txStrobe && !senseHalt |-> $past(rxValid) && $past(rxByte) == CMD_NULL)
      else $error("reply byte without null");
   AST_RESET_ACK: assert property (deviceResetReq |-> txStrobe && txByte == 8'hFB)
      else $error("reset without ack");
   AST_NV_ADDR: assert property (nvWrite.strobe |-> senseHalt && nvWrite.addr <= 7'h63)
      else $error("setup write out of range");
   AST_KEY_RANGE: assert property (calKeyStart |-> calKeyIndex <= 5'h17)
      else $error("key index out of range");
endmodule : touch_cmd_sva

bind touch_matrix_command_handler touch_cmd_sva chk (.*);

// >>> verif/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model
   import touch_cmd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       txStrobe,
   input  wire logic [7:0] txByte,
   output logic            rxValid,
   output logic      [7:0] rxByte
);
   initial
   begin
      rxValid = 1'b0;
      rxByte  = 8'hFF;
   end

   // Sends n copies back to back; a released data line shows the inverse of the last byte.
   task send(input logic [7:0] b, input int n);
      @(posedge clk);
      rxValid <= 1'b1;
      rxByte  <= b;
      repeat (n) @(posedge clk);
      rxValid <= 1'b0;
      rxByte  <= ~b;
   endtask : send

   // One null byte clocks out one reply byte.
   task pull(output logic seen, output logic [7:0] got);
      send(CMD_NULL, 1);
      #1;
      seen = txStrobe;
      got  = txByte;
   endtask : pull
endmodule : spi_host_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import touch_cmd_pkg::*;
;
   localparam int WIN = 50;
   logic          clk = 1'b0;
   logic          rst_b = 1'b0;
   logic          rxValid, txStrobe, slotStart, stuckKey, nvDone, senseHalt, calAllStart;
   logic          deviceResetReq, calKeyStart, nvProgram, fwdStrobe, commError, seen;
   logic [7:0]    rxByte, txByte, fwdCmd, got;
   logic [4:0]    slotKey, stuckKeyIndex, calKeyIndex;
   sense_status_t senseStatus;
   nv_write_t     nvWrite;
   int            failures = 0, num_checks = 0, cycles = 0, calAllCount = 0, wrIdx = 0;

   spi_host_model host (.clk(clk), .txStrobe(txStrobe), .txByte(txByte), .rxValid(rxValid), .rxByte(rxByte));
   touch_matrix_command_handler #(.WINDOW(WIN)) uut (.*);

   always #5 clk = ~clk;

   task automatic check(input string what, input logic [7:0] seenV, input logic [7:0] expV);
      num_checks++;
      if (seenV !== expV)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, expV, seenV);
      end
   endtask : check

   task end_of_test;
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   always @(posedge clk)
   begin
      cycles++;
      if (calAllStart)
         calAllCount++;
      if (nvWrite.strobe)
      begin
         check("nv addr", {1'b0, nvWrite.addr}, wrIdx[7:0]);
         check("nv data", nvWrite.data, wrIdx[7:0] ^ 8'h5A);
         wrIdx++;
      end
      if (cycles == 20000)
      begin
         failures++;
         end_of_test();
      end
   end

   function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] d);
      logic [7:0] c;
      c = crc ^ d;
      for (int i = 0; i < 8; i++)
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      return c;
   endfunction : crc8

   task doReset;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
   endtask : doReset

   task slot(input logic [4:0] k);
      @(posedge clk);
      slotStart <= 1'b1;
      slotKey   <= k;
      @(posedge clk);
      slotStart <= 1'b0;
      #1;
   endtask : slot

   task testStatus;
      @(posedge clk);
      senseStatus <= 5'b10101;
      host.send(CMD_STATUS, 1);
      host.pull(seen, got);
      check("status", got, 8'h25);
      host.pull(seen, got);
      check("status crc", got, crc8(crc8(CRC_INIT, CMD_STATUS), 8'h25));
      host.pull(seen, got);
      check("idle strobe", {7'h00, seen}, 8'h00);
   endtask : testStatus

   task testError;
      host.send(8'hD8, 2);
      host.pull(seen, got);
      check("bad key reply", {7'h00, seen}, 8'h00);
      check("bad key err", {7'h00, commError}, 8'h01);
      host.send(8'h02, 1);
      host.pull(seen, got);
      check("unknown reply", {7'h00, seen}, 8'h00);
      host.send(CMD_STATUS, 1);
      host.pull(seen, got);
      check("status err", got, 8'h65);
      host.send(8'h02, 1);
      host.send(CMD_LAST, 1);
      host.pull(seen, got);
      check("last cmd", got, 8'hFD);
      check("err clear", {7'h00, commError}, 8'h00);
      host.send(CMD_LAST, 1);
      host.pull(seen, got);
      check("last repeat", got, 8'hF0);
   endtask : testError

   task testCalAll;
      int c;
      c = calAllCount;
      host.send(CMD_CAL_ALL, 2);
      host.pull(seen, got);
      check("cal all ack", got, 8'hFC);
      host.send(CMD_CAL_ALL, 1);
      host.send(CMD_FIRST_KEY, 1);
      #1;
      check("fwd cmd", fwdStrobe ? fwdCmd : 8'hFF, CMD_FIRST_KEY);
      host.send(CMD_CAL_ALL, 1);
      repeat (WIN + 5) @(posedge clk);
      host.send(CMD_CAL_ALL, 1);
      repeat (WIN + 5) @(posedge clk);
      check("cal all count", 8'(calAllCount - c), 8'h01);
      host.pull(seen, got);
      check("no timeout reply", {7'h00, seen}, 8'h00);
      host.send(CMD_CAL_ALL, 2);
      host.pull(seen, got);
      check("reissue ack", got, 8'hFC);
   endtask : testCalAll

   task testKey;
      host.send(8'hC5, 2);
      slot(5'h04);
      check("other slot", {7'h00, calKeyStart}, 8'h00);
      slot(5'h05);
      check("key start", {7'h00, calKeyStart}, 8'h01);
      check("key index", {3'h0, calKeyIndex}, 8'h05);
      host.pull(seen, got);
      check("key ack", got, 8'h3A);
      @(posedge clk);
      stuckKey      <= 1'b1;
      stuckKeyIndex <= 5'h07;
      @(posedge clk);
      stuckKey <= 1'b0;
      slot(5'h07);
      check("stuck index", {2'h0, calKeyStart, calKeyIndex}, 8'h27);
      host.pull(seen, got);
      check("stuck no ack", {7'h00, seen}, 8'h00);
   endtask : testKey

   task testReset;
      host.send(CMD_RESET, 2);
      host.pull(seen, got);
      check("reset ack", got, 8'hFB);
      check("reset pulse", {7'h00, deviceResetReq}, 8'h01);
   endtask : testReset

   task testSetup(input logic [1:0] mode);
      logic [7:0] crc;
      crc = CRC_INIT;
      host.send(CMD_SETUP, 2);
      #1;
      check("halt", {7'h00, senseHalt}, 8'h01);
      host.pull(seen, got);
      check("ready", got, ACK_READY);
      wrIdx = 0;
      for (int i = 0; i < 100; i++)
      begin
         host.send(i[7:0] ^ 8'h5A, 1);
         crc = crc8(crc, i[7:0] ^ 8'h5A);
      end
      host.send(mode == 2'h0 ? crc : (mode == 2'h1 ? CRC_SKIP : ~crc), 1);
      #1;
      check("program", {7'h00, nvProgram}, 8'h01);
      @(posedge clk);
      nvDone <= 1'b1;
      @(posedge clk);
      nvDone <= 1'b0;
      host.pull(seen, got);
      check("done", got, mode == 2'h2 ? ACK_CRC_FAIL : ACK_READY);
      check("write count", wrIdx[7:0], 8'h64);
      check("resume", {7'h00, senseHalt}, 8'h00);
   endtask : testSetup

   task testSetupTimeout;
      host.send(CMD_SETUP, 2);
      host.pull(seen, got);
      wrIdx = 0;
      host.send(8'h5A, 1);
      repeat (WIN + 5) @(posedge clk);
      #1;
      check("timeout halt", {7'h00, senseHalt}, 8'h00);
      host.pull(seen, got);
      check("timeout reply", {7'h00, seen}, 8'h00);
   endtask : testSetupTimeout

   initial
   begin
      senseStatus   = '0;
      slotStart     = 1'b0;
      slotKey       = 5'h00;
      stuckKey      = 1'b0;
      stuckKeyIndex = 5'h00;
      nvDone        = 1'b0;
      doReset();
      testStatus();
      testError();
      testCalAll();
      testKey();
      testReset();
      doReset();
      testSetup(2'h0);
      testSetup(2'h1);
      testSetup(2'h2);
      testSetupTimeout();
      testSetup(2'h0);
      doReset();
      end_of_test();
   end
endmodule : tb_top
